// [verilog/tac_conv_ctrl.sv]
`timescale 1ns/10ps
module tac_conv_ctrl
  import tac_pkg::*;
#(
  parameter int TMR_LONG_TICKS = TMR_T3_TICKS
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [AXI_AW-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [AXI_AW-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              touch_pin,
  output logic                   conv_start,
  output logic [3:0]             conv_channel,
  output logic                   conv_ratiometric,
  input  wire logic              conv_done,
  input  wire logic [11:0]       conv_result,
  output logic                   sw_x_plus,
  output logic                   sw_x_minus,
  output logic                   sw_y_plus,
  output logic                   sw_y_minus,
  output logic                   data_ready_n,
  output logic                   limit_alarm_n
);

  logic [1:0]        touch_sync_q;
  logic              touch_prev_q;
  logic [5:0]        div_cnt_q;
  logic              tick_q;
  logic              aw_hold_q, w_hold_q;
  logic [4:0]        wr_idx_q;
  logic [11:0]       wdata_q;
  logic [1:0]        wstrb_q;
  logic [11:0]       ctrl1_q, ctrl2_q, seq0_q, seq1_q;
  logic [11:0]       limit_q [0:7];
  logic [11:0]       result_q [0:NUM_CH-1];
  logic [3:0]        status_q, mask_q;
  tac_state_t        st_q, st_d;
  logic [3:0]        idx_q;
  logic              arm_q, wrote_q;
  logic [14:0]       tmr_cnt_q;

  // Touch pin crosses in through two flops; the first is read by nothing else
  wire touch      = touch_sync_q[1];
  wire touch_rise = touch & ~touch_prev_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      touch_sync_q <= 2'h0;
      touch_prev_q <= 1'b0;
    end else begin
      touch_sync_q <= {touch_sync_q[0], touch_pin};
      touch_prev_q <= touch;
    end
  end

  // Conversion clock as a one-cycle enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt_q <= 6'h00;
      tick_q    <= 1'b0;
    end else begin
      tick_q    <= (div_cnt_q == 6'(CONV_DIV - 1));
      div_cnt_q <= (div_cnt_q == 6'(CONV_DIV - 1)) ? 6'h00 : div_cnt_q + 6'h01;
    end
  end

  // AXI4-Lite write: address and data taken in either order
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take  = s_axi_wvalid & s_axi_wready;
  wire wr_fire = aw_hold_q & w_hold_q & ~s_axi_bvalid;
  wire b_done  = s_axi_bvalid & s_axi_bready;
  wire wr_lim  = (wr_idx_q >= IDX_LIMIT_BASE) && (wr_idx_q <= IDX_LIMIT_LAST);
  wire wr_ok   = (wr_idx_q == IDX_CTRL1) | (wr_idx_q == IDX_CTRL2) | (wr_idx_q == IDX_ALERT)
               | (wr_idx_q == IDX_SEQ0) | (wr_idx_q == IDX_SEQ1) | wr_lim;
  wire [2:0] wr_lim_sel = 3'(wr_idx_q - IDX_LIMIT_BASE);

  function automatic logic [11:0] merge(input logic [11:0] old, input logic [11:0] nw,
                                        input logic [1:0] be);
    merge = {be[1] ? nw[11:8] : old[11:8], be[0] ? nw[7:0] : old[7:0]};
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q     <= 1'b0;
      w_hold_q      <= 1'b0;
      wr_idx_q      <= 5'h00;
      wdata_q       <= REG_RESET;
      wstrb_q       <= 2'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_hold_q     <= 1'b1;
        wr_idx_q      <= s_axi_awaddr[6:2];
        s_axi_awready <= 1'b0;
      end
      if (w_take) begin
        w_hold_q     <= 1'b1;
        wdata_q      <= s_axi_wdata[11:0];
        wstrb_q      <= s_axi_wstrb[1:0];
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      if (b_done) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // AXI4-Lite read: one beat, answer the cycle after the address is taken
  wire [4:0] rd_idx  = s_axi_araddr[6:2];
  wire       ar_take = s_axi_arvalid & s_axi_arready;
  wire       rd_lim  = (rd_idx >= IDX_LIMIT_BASE) && (rd_idx <= IDX_LIMIT_LAST);
  wire       rd_res  = (rd_idx >= IDX_RESULT_BASE) && (rd_idx <= IDX_RESULT_LAST);
  wire [2:0] rd_lsel = 3'(rd_idx - IDX_LIMIT_BASE);
  wire [3:0] rd_rsel = 4'(rd_idx - IDX_RESULT_BASE);
  wire       rd_ok   = rd_lim | rd_res | (rd_idx == IDX_CTRL1) | (rd_idx == IDX_CTRL2)
                     | (rd_idx == IDX_ALERT) | (rd_idx == IDX_SEQ0) | (rd_idx == IDX_SEQ1);
  wire [11:0] rd_val = (rd_idx == IDX_CTRL1) ? ctrl1_q :
                       (rd_idx == IDX_CTRL2) ? ctrl2_q :
                       (rd_idx == IDX_SEQ0)  ? seq0_q  :
                       (rd_idx == IDX_SEQ1)  ? seq1_q  :
                       (rd_idx == IDX_ALERT) ? {4'h0, mask_q, status_q} :
                       rd_lim                ? limit_q[rd_lsel] :
                       rd_res                ? result_q[rd_rsel] : 12'h000;
  wire       rd_result = ar_take & rd_res;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (ar_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {20'h00000, rd_val};
      s_axi_rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Control decode
  wire        wr_any    = wr_fire & (|wstrb_q);
  wire        ctrl1_wr  = wr_any & (wr_idx_q == IDX_CTRL1);
  wire [11:0] ctrl1_new = merge(ctrl1_q, wdata_q, wstrb_q);
  wire [1:0]  mode      = ctrl1_q[MODE_LSB+:2];
  wire [1:0]  new_mode  = ctrl1_new[MODE_LSB+:2];
  wire [3:0]  chan_code = ctrl1_q[CHAN_LSB+:4];
  wire        ratio_sel = ctrl1_q[REFSEL_BIT];
  wire [1:0]  tmr_sel   = ctrl2_q[TMR_LSB+:2];
  wire        single    = (mode == MODE_SINGLE);
  wire        master    = (mode == MODE_SEQ1);
  wire        chan_ok   = (chan_code <= CH_LAST);
  wire [11:0] seq_bits  = master ? seq1_q : seq0_q;
  wire [NUM_CH-1:0] ch_en;
  for (genvar i = 0; i < NUM_CH; i++) begin : g_en
    assign ch_en[i] = seq_bits[SEQ_TOP - i];
  end

  wire        idx_over  = (idx_q > CH_LAST);
  wire        scan_go   = single ? chan_ok : (~idx_over & ch_en[idx_q]);
  wire        scan_end  = single ? ~chan_ok : idx_over;
  wire        start     = (st_q == ST_SCAN) & scan_go & ~ctrl1_wr;
  wire [3:0]  chan_d    = start ? (single ? chan_code : idx_q) : conv_channel;
  wire        store     = (st_q == ST_CONV) & conv_done;
  wire [14:0] tmr_last  = (tmr_sel == TMR_SHORT) ? 15'(TMR_T1_TICKS - 1) :
                          (tmr_sel == TMR_MID)   ? 15'(TMR_T2_TICKS - 1) :
                                                   15'(TMR_LONG_TICKS - 1);
  wire        tmr_exp   = tick_q & (tmr_cnt_q == tmr_last);
  wire        tmr_on    = (tmr_sel != TMR_ONCE);
  wire        slave_clr = (st_q == ST_DONE) & ~master & ~tmr_on & ~ctrl1_wr;
  wire        restart   = (st_q == ST_TIMER) & tmr_exp & ~(master & ~touch) & ~ctrl1_wr;

  // Sequencer next state
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_IDLE:  st_d = ST_IDLE;
      ST_WAIT:  if (touch_rise || (arm_q && touch)) st_d = ST_SCAN;
      ST_SCAN:  if (start) st_d = ST_CONV;
                else if (scan_end) st_d = ST_DONE;
      ST_CONV:  if (conv_done) st_d = single ? ST_DONE : ST_SCAN;
      ST_DONE:  if (master) st_d = (touch && tmr_on) ? ST_TIMER : ST_WAIT;
                else st_d = tmr_on ? ST_TIMER : ST_IDLE;
      ST_TIMER: if (master && !touch) st_d = ST_WAIT;
                else if (tmr_exp) st_d = ST_SCAN;
    endcase
    if (ctrl1_wr) begin
      unique case (new_mode)
        MODE_IDLE:   st_d = ST_IDLE;
        MODE_SEQ1:   st_d = ST_WAIT;
        MODE_SINGLE,
        MODE_SEQ0:   st_d = ST_SCAN;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q      <= ST_IDLE;
      idx_q     <= 4'h0;
      arm_q     <= 1'b0;
      wrote_q   <= 1'b0;
      tmr_cnt_q <= 15'h0000;
    end else begin
      st_q <= st_d;
      if (ctrl1_wr || restart || (st_q == ST_WAIT)) begin
        idx_q   <= 4'h0;
        wrote_q <= 1'b0;
      end else begin
        if ((st_q == ST_SCAN && !scan_go && !idx_over) || (store && !single)) begin
          idx_q <= idx_q + 4'h1;
        end
        if (store) wrote_q <= 1'b1;
      end
      if (ctrl1_wr) arm_q <= (new_mode == MODE_SEQ1);
      else if (st_q == ST_SCAN) arm_q <= 1'b0;
      if (st_q != ST_TIMER) tmr_cnt_q <= 15'h0000;
      else if (tick_q) tmr_cnt_q <= tmr_exp ? 15'h0000 : tmr_cnt_q + 15'h0001;
    end
  end

  // Configuration registers; hardware clear of the mode field yields to a host write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl1_q <= REG_RESET;
      ctrl2_q <= REG_RESET;
      seq0_q  <= REG_RESET;
      seq1_q  <= REG_RESET;
      mask_q  <= 4'h0;
      for (int k = 0; k < 8; k++) limit_q[k] <= REG_RESET;
    end else begin
      if (ctrl1_wr) ctrl1_q <= ctrl1_new;
      else if (slave_clr) ctrl1_q[MODE_LSB+:2] <= MODE_IDLE;
      if (wr_any && wr_idx_q == IDX_CTRL2) ctrl2_q <= merge(ctrl2_q, wdata_q, wstrb_q);
      if (wr_any && wr_idx_q == IDX_SEQ0) seq0_q <= merge(seq0_q, wdata_q, wstrb_q);
      if (wr_any && wr_idx_q == IDX_SEQ1) seq1_q <= merge(seq1_q, wdata_q, wstrb_q);
      if (wr_fire && wstrb_q[0] && wr_idx_q == IDX_ALERT) mask_q <= wdata_q[ALERT_MASK_LSB+:4];
      if (wr_any && wr_lim) limit_q[wr_lim_sel] <= merge(limit_q[wr_lim_sel], wdata_q, wstrb_q);
    end
  end

  // Results: only a finished valid conversion writes its own slot
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int k = 0; k < NUM_CH; k++) result_q[k] <= REG_RESET;
    end else if (store) begin
      result_q[conv_channel] <= conv_result;
    end
  end

  // Limit check on raw codes, temperature included, no scaling
  wire [3:0] lim_hit;
  for (genvar k = 0; k < 4; k++) begin : g_lim
    assign lim_hit[k] = store && (conv_channel == LIM_CH[4*k+:4])
                     && ((conv_result > limit_q[2*k])
                      || (conv_result < limit_q[2*k+1]));
  end
  wire [3:0] status_clr = (wr_fire && wstrb_q[0] && wr_idx_q == IDX_ALERT) ? wdata_q[3:0] : 4'h0;
  wire [3:0] status_d   = (status_q & ~status_clr) | lim_hit;

  // Outputs, all registered
  wire in_conv_d = (st_d == ST_CONV);
  wire z_d       = (chan_d == CH_Z2) | (chan_d == CH_Z1);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_q         <= 4'h0;
      limit_alarm_n    <= 1'b1;
      data_ready_n     <= 1'b1;
      conv_start       <= 1'b0;
      conv_channel     <= 4'h0;
      conv_ratiometric <= 1'b0;
      sw_x_plus        <= 1'b0;
      sw_x_minus       <= 1'b0;
      sw_y_plus        <= 1'b0;
      sw_y_minus       <= 1'b0;
    end else begin
      status_q      <= status_d;
      limit_alarm_n <= ~|(status_d & ~mask_q);
      // New results win over a simultaneous read
      if (st_q == ST_DONE && wrote_q) data_ready_n <= 1'b0;
      else if (rd_result || restart || ctrl1_wr) data_ready_n <= 1'b1;
      conv_start   <= start;
      conv_channel <= chan_d;
      if (start) conv_ratiometric <= ratio_sel;
      sw_y_plus    <= in_conv_d & ((chan_d == CH_Y) | z_d);
      sw_y_minus   <= in_conv_d & (chan_d == CH_Y);
      sw_x_plus    <= in_conv_d & (chan_d == CH_X);
      sw_x_minus   <= in_conv_d & ((chan_d == CH_X) | z_d);
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_MODE_CLEAR: assert property (slave_clr |=> ctrl1_q[MODE_LSB+:2] == MODE_IDLE)
    else $error("mode field not cleared after slave work");
  AST_DAV_LOW: assert property ((st_q == ST_DONE) && wrote_q |=> !data_ready_n)
    else $error("data ready did not fall after results");
  AST_DAV_READ: assert property (rd_result && (st_q != ST_DONE) |=> data_ready_n)
    else $error("result read did not raise data ready");
  AST_ALARM: assert property (store && lim_hit != 4'h0 && mask_q == 4'h0 && !wr_fire
                               |=> !limit_alarm_n && (status_q != 4'h0))
    else $error("limit violation did not raise alarm");
  AST_INVALID: assert property ((st_q == ST_SCAN) && single && !chan_ok |=> !conv_start)
    else $error("conversion started on invalid channel");
  AST_NO_TOUCH: assert property ((st_q == ST_WAIT) && !touch && !ctrl1_wr
                                 |=> !conv_start ##1 !conv_start)
    else $error("master conversion without touch");
  AST_RELEASE: assert property ((st_q == ST_TIMER) && master && !touch && !ctrl1_wr
                                |=> st_q == ST_WAIT)
    else $error("timer kept running after release");
  AST_SLAVE_TMR: assert property ((st_q == ST_DONE) && !master && tmr_on && !ctrl1_wr
                                  |=> (st_q == ST_TIMER) && (tmr_cnt_q == 15'h0000))
    else $error("slave timer did not start");
  AST_CHAN: assert property (conv_start && single |-> conv_channel == chan_code
                             && conv_ratiometric == ratio_sel)
    else $error("single conversion on wrong channel or reference");
  AST_SKIP: assert property ((st_q == ST_SCAN) && !single && !idx_over && !ch_en[idx_q]
                             |=> !conv_start)
    else $error("disabled channel converted");
  AST_SW_Y: assert property (conv_start && conv_channel == CH_Y
                             |-> sw_y_plus && sw_y_minus && !sw_x_plus && !sw_x_minus)
    else $error("Y plate switches wrong");

  COV_SINGLE: cover property (single && store ##[1:4] !data_ready_n);
  COV_SEQ_RPT: cover property (restart && !master);
  COV_MASTER: cover property (master && touch_rise ##[1:20] conv_start);
  COV_ALARM: cover property (lim_hit != 4'h0 ##1 !limit_alarm_n);

endmodule

// [include/tac_pkg.sv]
package tac_pkg;
  // Bus geometry: each register sits at byte address 4 x index
  localparam int          AXI_AW          = 7;
  localparam int          REG_W           = 12;
  localparam logic [4:0]  IDX_CTRL1       = 5'h01;
  localparam logic [4:0]  IDX_CTRL2       = 5'h02;
  localparam logic [4:0]  IDX_LIMIT_BASE  = 5'h04;
  localparam logic [4:0]  IDX_LIMIT_LAST  = 5'h0b;
  localparam logic [4:0]  IDX_ALERT       = 5'h0c;
  localparam logic [4:0]  IDX_SEQ0        = 5'h0d;
  localparam logic [4:0]  IDX_SEQ1        = 5'h0e;
  localparam logic [4:0]  IDX_RESULT_BASE = 5'h10;
  localparam logic [4:0]  IDX_RESULT_LAST = 5'h1a;
  localparam logic [11:0] REG_RESET       = 12'h000;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  // Field positions
  localparam int MODE_LSB   = 0;
  localparam int CHAN_LSB   = 7;
  localparam int REFSEL_BIT = 11;
  localparam int TMR_LSB    = 0;
  localparam int SEQ_TOP    = 11;
  localparam int ALERT_MASK_LSB = 4;

  localparam logic [1:0] MODE_IDLE   = 2'h0;
  localparam logic [1:0] MODE_SINGLE = 2'h1;
  localparam logic [1:0] MODE_SEQ0   = 2'h2;
  localparam logic [1:0] MODE_SEQ1   = 2'h3;
  localparam logic [1:0] TMR_ONCE    = 2'h0;
  localparam logic [1:0] TMR_SHORT   = 2'h1;
  localparam logic [1:0] TMR_MID     = 2'h2;

  // Channel codes
  localparam int         NUM_CH   = 11;
  localparam logic [3:0] CH_Y     = 4'h0;
  localparam logic [3:0] CH_X     = 4'h1;
  localparam logic [3:0] CH_Z2    = 4'h2;
  localparam logic [3:0] CH_AUX_INPUT_ONE  = 4'h3;
  localparam logic [3:0] CH_BATTERY_INPUT_ONE  = 4'h6;
  localparam logic [3:0] CH_BATTERY_INPUT_TWO  = 4'h7;
  localparam logic [3:0] CH_DIODE_TEMP_FIRST = 4'h8;
  localparam logic [3:0] CH_Z1    = 4'ha;
  localparam logic [3:0] CH_LAST  = 4'ha;
  // Limit slot k watches channel LIM_CH[4k+:4]
  localparam logic [15:0] LIM_CH  = {CH_DIODE_TEMP_FIRST, CH_BATTERY_INPUT_TWO, CH_BATTERY_INPUT_ONE, CH_AUX_INPUT_ONE};

  // Timing: conversion clock derived from aclk
  localparam int ACLK_NS       = 10;
  localparam int CONV_CLK_NS   = 500;
  localparam int CONV_DIV      = CONV_CLK_NS / ACLK_NS;
  localparam int TMR_T1_TICKS  = 1024;
  localparam int TMR_T2_TICKS  = 2048;
  localparam int TMR_T3_TICKS  = 16384;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_WAIT  = 6'h02,
    ST_SCAN  = 6'h04,
    ST_CONV  = 6'h08,
    ST_DONE  = 6'h10,
    ST_TIMER = 6'h20
  } tac_state_t;
endpackage

// [bench/tac_conv_model.sv]
`timescale 1ns/10ps
// Converter stand-in: answers promptly or slowly; result encodes reference and channel
module tac_conv_model (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        slow,
  input  wire logic        conv_start,
  input  wire logic [3:0]  conv_channel,
  input  wire logic        conv_ratiometric,
  output logic             conv_done,
  output logic [11:0]      conv_result
);
  logic [5:0]  cnt_q;
  logic        busy_q;
  logic [11:0] hold_q;
  always_ff @(posedge aclk) begin
    conv_done   <= 1'b0;
    // Toggles between answers so stale data never passes as a result
    conv_result <= ~conv_result;
    if (!aresetn) begin
      busy_q      <= 1'b0;
      conv_result <= 12'h000;
    end else if (conv_start) begin
      busy_q <= 1'b1;
      cnt_q  <= slow ? 6'h28 : 6'h01;
      hold_q <= {conv_ratiometric, 3'h0, conv_channel, 4'h5};
    end else if (busy_q && cnt_q == 6'h00) begin
      busy_q      <= 1'b0;
      conv_done   <= 1'b1;
      conv_result <= hold_q;
    end else if (busy_q) begin
      cnt_q <= cnt_q - 6'h01;
    end
  end
endmodule

// [bench/touch_adc_conversion_control_tb_top.sv]
`timescale 1ns/10ps
module touch_adc_conversion_control_tb_top;
  import tac_pkg::*;
  logic              aclk, aresetn, touch_pin, slow, conv_start, conv_ratiometric, conv_done;
  logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic              s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic              sw_x_plus, sw_x_minus, sw_y_plus, sw_y_minus, data_ready_n, limit_alarm_n;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic [2:0]        s_axi_awprot, s_axi_arprot;
  logic [3:0]        s_axi_wstrb, conv_channel;
  logic [AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
  logic [11:0]       conv_result;
  logic [31:0]       s_axi_wdata, s_axi_rdata;
  int                fails, tests_run, cyc, starts, s0, n;
  wire  [3:0]        sw_now = {sw_x_plus, sw_x_minus, sw_y_plus, sw_y_minus};

  // Long timer period shortened so repeat runs stay brief
  tac_conv_ctrl #(.TMR_LONG_TICKS(8)) u_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .touch_pin, .conv_start,
    .conv_channel, .conv_ratiometric, .conv_done, .conv_result, .sw_x_plus, .sw_x_minus,
    .sw_y_plus, .sw_y_minus, .data_ready_n, .limit_alarm_n);
  tac_conv_model u_conv (.aclk, .aresetn, .slow, .conv_start, .conv_channel,
    .conv_ratiometric, .conv_done, .conv_result);

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  function automatic logic [3:0] sw_exp(input logic [3:0] ch);
    case (ch)
      4'h0: return 4'h3;
      4'h1: return 4'hc;
      4'h2, 4'ha: return 4'h6;
      default: return 4'h0;
    endcase
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("FAIL at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic fl(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask

  task automatic give_verdict();
    $display("Counts: %0d comparisons, %0d mismatches", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Every start is checked against the panel switch pattern of its channel
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (conv_start === 1'b1) begin
      starts <= starts + 1;
      chk({28'h0, sw_now}, {28'h0, sw_exp(conv_channel)});
    end
    if (cyc == 20000) begin
      fails++;
      give_verdict();
    end
  end

  task automatic wr(input logic [6:0] a, input logic [31:0] d, input logic [1:0] er);
    int k = 0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (s_axi_bvalid !== 1'b1 && k < 100) begin
      @(posedge aclk);
      k++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    fl(s_axi_bvalid, 1'b1);
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [6:0] a, input logic [31:0] e, input logic [1:0] er);
    int k = 0;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (s_axi_rvalid !== 1'b1 && k < 100) begin
      @(posedge aclk);
      k++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, e);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask

  task automatic wait_low(input int lim);
    int k = 0;
    while (data_ready_n !== 1'b0 && k < lim) begin
      @(posedge aclk);
      k++;
    end
    fl(data_ready_n, 1'b0);
  endtask

  // Cycles until the next start, capped at lim
  task automatic gap(input int lim, output int k);
    k = 0;
    while (conv_start !== 1'b1 && k < lim) begin
      @(posedge aclk);
      k++;
    end
  endtask

  initial begin
    {aresetn, touch_pin, slow} = 3'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    {fails, tests_run, cyc, starts} = '0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(7'h04, 32'h000, RESP_OKAY);
    rd(7'h08, 32'h000, RESP_OKAY);
    rd(7'h00, 32'h000, RESP_SLVERR);
    wr(7'h7c, 32'h001, RESP_SLVERR);
    fl(limit_alarm_n, 1'b1);
    $display("Test reset_map done");
    wr(7'h10, 32'h200, RESP_OKAY);
    wr(7'h14, 32'h010, RESP_OKAY);
    wr(7'h04, 32'h181, RESP_OKAY);
    wait_low(100);
    rd(7'h30, 32'h000, RESP_OKAY);
    rd(7'h4c, 32'h035, RESP_OKAY);
    repeat (3) @(posedge aclk);
    fl(data_ready_n, 1'b1);
    rd(7'h04, 32'h180, RESP_OKAY);
    wr(7'h04, 32'hc01, RESP_OKAY);
    wait_low(100);
    rd(7'h60, 32'h885, RESP_OKAY);
    rd(7'h30, 32'h008, RESP_OKAY);
    fl(limit_alarm_n, 1'b0);
    wr(7'h30, 32'h008, RESP_OKAY);
    fl(limit_alarm_n, 1'b1);
    $display("Test single_limits done");
    s0 = starts;
    wr(7'h04, 32'h581, RESP_OKAY);
    repeat (20) @(posedge aclk);
    chk(starts - s0, 0);
    rd(7'h04, 32'h580, RESP_OKAY);
    rd(7'h4c, 32'h035, RESP_OKAY);
    $display("Test invalid_channel done");
    slow <= 1'b1;
    wr(7'h34, 32'hc02, RESP_OKAY);
    s0 = starts;
    wr(7'h04, 32'h002, RESP_OKAY);
    wait_low(500);
    chk(starts - s0, 3);
    rd(7'h40, 32'h005, RESP_OKAY);
    rd(7'h44, 32'h015, RESP_OKAY);
    rd(7'h68, 32'h0a5, RESP_OKAY);
    rd(7'h04, 32'h000, RESP_OKAY);
    slow <= 1'b0;
    $display("Test slave_sequence done");
    wr(7'h08, 32'h003, RESP_OKAY);
    wr(7'h04, 32'h301, RESP_OKAY);
    wait_low(100);
    gap(600, n);
    fl(n >= 340 && n <= 420, 1'b1);
    repeat (2) @(posedge aclk);
    fl(data_ready_n, 1'b1);
    wr(7'h04, 32'h000, RESP_OKAY);
    // Battery one result sits above its zero high limit, so its alert is set
    fl(limit_alarm_n, 1'b0);
    wr(7'h30, 32'h020, RESP_OKAY);
    rd(7'h30, 32'h022, RESP_OKAY);
    fl(limit_alarm_n, 1'b1);
    $display("Test repeat_timer done");
    wr(7'h38, 32'h800, RESP_OKAY);
    wr(7'h04, 32'h003, RESP_OKAY);
    gap(200, n);
    chk(n, 200);
    touch_pin <= 1'b1;
    gap(20, n);
    fl(n < 20, 1'b1);
    repeat (2) @(posedge aclk);
    gap(600, n);
    fl(n >= 330 && n <= 420, 1'b1);
    // Release only once the timer is running
    repeat (40) @(posedge aclk);
    touch_pin <= 1'b0;
    repeat (2) @(posedge aclk);
    gap(900, n);
    chk(n, 900);
    touch_pin <= 1'b1;
    gap(20, n);
    fl(n < 20, 1'b1);
    wr(7'h04, 32'h000, RESP_OKAY);
    $display("Test master_touch done");
    give_verdict();
  end
endmodule
